// [pkg/fpc_mem_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface fpc_mem_if;
  logic req;
  logic we;
  logic [14:0] addr;
  logic [11:0] wdata;
  logic [11:0] rdata;
  logic ack;
  modport master(output req, we, addr, wdata, input rdata, ack);
  modport port(input req, we, addr, wdata, output rdata, ack);
endinterface
`default_nettype wire

// [pkg/fpc_pkg.sv]
package fpc_pkg;
  localparam int AW = 15;
  localparam int WW = 12;
  // table word offsets
  localparam logic [2:0] TB_FIELD = 3'h0;
  localparam logic [2:0] TB_PC = 3'h1;
  localparam logic [2:0] TB_XB = 3'h2;
  localparam logic [2:0] TB_BASE = 3'h3;
  localparam logic [2:0] TB_OPA = 3'h4;
  localparam logic [2:0] TB_EXP = 3'h5;
  localparam logic [2:0] TB_HI = 3'h6;
  localparam logic [2:0] TB_LO = 3'h7;
  // opcode field codes and other constants
  localparam logic [2:0] OP_LOAD = 3'h0;
  localparam logic [2:0] OP_STORE = 3'h6;
  localparam logic [2:0] FMT_DIRECT = 3'h4;
  localparam logic [2:0] FMT_BASE1 = 3'h2;
  localparam logic [2:0] FMT_SPEC = 3'h0;
  localparam logic [2:0] FMT_JUMP = 3'h1;
  localparam logic [2:0] SP_LOOP = 3'h2;
  localparam logic [5:0] SP_LDX = 6'h08;
  localparam logic [5:0] SP_ADD_TO_INDEX = 6'h09;
  localparam logic [2:0] PT_SETX = 3'h0;
  localparam logic [2:0] PT_SETB = 3'h1;
  localparam logic [2:0] PT_LINK = 3'h2;
  localparam logic [2:0] PT_CALL = 3'h3;
  localparam logic [2:0] OPR_EXIT = 3'h0;
  localparam logic [2:0] OPR_FLT = 3'h5;
  localparam logic [2:0] OPR_FIX = 3'h6;
  localparam logic [2:0] OPR_AJMP = 3'h7;
  localparam logic [2:0] CJ_ZERO = 3'h0;
  localparam logic [2:0] CJ_NNEG = 3'h1;
  localparam logic [2:0] CJ_NPOS = 3'h2;
  localparam logic [2:0] CJ_ALW = 3'h3;
  localparam logic [2:0] CJ_NZ = 3'h4;
  localparam logic [2:0] CJ_NEG = 3'h5;
  localparam logic [2:0] CJ_POS = 3'h6;
  localparam logic [2:0] CJ_FIX = 3'h7;
  localparam logic [11:0] FIX_LIMIT = 12'h017;
  localparam logic [1:0] MUL_FLT = 2'h3;
  localparam logic [1:0] MUL_FIX = 2'h2;
  localparam logic [11:0] JUMP_WORD = 12'h103;
  localparam logic [2:0] STAT_DONE = 3'h0;
  typedef enum logic [10:0] {
    FPC_IDLE = 11'h001, FPC_LOAD = 11'h002, FPC_FETCH = 11'h004,
    FPC_FETCH2 = 11'h008, FPC_XRD = 11'h010, FPC_XWR = 11'h020,
    FPC_DATA = 11'h040, FPC_INDR = 11'h080, FPC_WR = 11'h100,
    FPC_DUMP = 11'h200, FPC_DONE = 11'h400
  } fpc_state_e;
endpackage

// [testbench/fp_coprocessor_param_table_addressing_test.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, a); end end
module fp_coprocessor_param_table_addressing_test;
  logic clk, rst_b, start_iot, flag_skip, skip, irq, run, slow;
  logic mem_req, mem_we, mem_ack;
  logic [14:0] ptr, mem_addr;
  logic [11:0] status, mem_wdata, mem_rdata;
  logic [11:0] sm [0:32767];
  logic [27:0] exp_q [$];
  logic [31:0] seed;
  int miscompares, n_tests;
  fpc_core dut (.core_clk_in(clk), .rst_b_in(rst_b), .start_iot_in(start_iot),
    .param_table_in(ptr), .flag_skip_iot_in(flag_skip), .skip_out(skip),
    .status_out(status), .irq_out(irq), .run_out(run), .mem_req_out(mem_req),
    .mem_we_out(mem_we), .mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata),
    .mem_rdata_in(mem_rdata), .mem_ack_in(mem_ack));
  fpc_host_mem mdl (.core_clk_in(clk), .slow_in(slow), .mem_req_in(mem_req),
    .mem_we_in(mem_we), .mem_addr_in(mem_addr), .mem_wdata_in(mem_wdata),
    .mem_rdata_out(mem_rdata), .mem_ack_out(mem_ack));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic poke(input logic [14:0] a, input logic [11:0] v);
    sm[a] = v;
    mdl.mem[a] = v;
  endtask
  task automatic rnd3(input logic [14:0] a);
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      poke(15'(a + k), seed[11:0]);
    end
  endtask
  task automatic set_table(input logic [14:0] p, pc, xb, bs);
    poke(p, {pc[14:12], xb[14:12], bs[14:12], 3'h0});
    poke(p + 15'h1, pc[11:0]);
    poke(p + 15'h2, xb[11:0]);
    poke(p + 15'h3, bs[11:0]);
    rnd3(p + 15'h4);
    rnd3(p + 15'h5);
  endtask
  function automatic logic [11:0] rd(input logic [14:0] a);
    exp_q.push_back({1'b0, a, 12'h000});
    return sm[a];
  endfunction
  task automatic wr(input logic [14:0] a, input logic [11:0] v);
    exp_q.push_back({1'b1, a, v});
    sm[a] = v;
  endtask
  task automatic model_run(input logic [14:0] p);
    logic [11:0] w [8];
    logic [14:0] pc, xb, bs, oa, a;
    logic [11:0] ins, ex, hi, lo, x;
    logic fx = 1'b0;
    exp_q.delete();
    for (int k = 0; k < 8; k++) begin
      w[k] = (k == 4) ? 12'h000 : rd(15'(p + k));
    end
    pc = {w[0][11:9], w[1]};
    xb = {w[0][8:6], w[2]};
    bs = {w[0][5:3], w[3]};
    oa = 15'h0000;
    ex = w[5];
    hi = w[6];
    lo = w[7];
    ins = 12'hFFF;
    while (ins != 12'h000) begin
      ins = rd(pc);
      pc = pc + 15'h1;
      if (ins == {9'h000, fpc_pkg::OPR_FIX}) fx = 1'b1;
      if ({ins[8:7], 1'b0} == fpc_pkg::FMT_DIRECT) begin
        a = {ins[2:0], rd(pc)};
        pc = pc + 15'h1;
        if (ins[5:3] != 3'h0) begin
          x = rd(xb + ins[5:3]) + 12'(ins[6]);
          if (ins[6]) wr(xb + ins[5:3], x);
          a = 15'(int'(a) + (fx ? 2 : 3) * int'($signed(x)));
        end
        oa = a;
        if (!fx) ex = rd(a);
        hi = rd(a + 15'(!fx));
        lo = rd(a + 15'(!fx) + 15'h1);
      end
    end
    wr(p + 15'h7, lo);
    wr(p + 15'h6, hi);
    wr(p + 15'h5, ex);
    wr(p + 15'h4, oa[11:0]);
    wr(p + 15'h3, bs[11:0]);
    wr(p + 15'h2, xb[11:0]);
    wr(p + 15'h1, pc[11:0]);
    wr(p, {pc[14:12], xb[14:12], bs[14:12], oa[14:12]});
  endtask
  task automatic run_prog(input logic [14:0] p, input logic sl, bump);
    int t;
    model_run(p);
    mdl.log_q.delete();
    slow = sl;
    ptr = p;
    start_iot = 1'b1;
    @(negedge clk);
    start_iot = 1'b0;
    if (bump) begin
      repeat (3) @(negedge clk);
      ptr = p ^ 15'h0100;
      start_iot = 1'b1;
      @(negedge clk);
      start_iot = 1'b0;
    end
    t = 0;
    while (irq !== 1'b1 && t < 3000) begin
      @(negedge clk);
      t++;
    end
    `CHK("done flag", 1'b1, irq)
    `CHK("run", 1'b0, run)
    `CHK("status done", 12'h001, status)
    `CHK("access count", exp_q.size(), mdl.log_q.size())
    for (int i = 0; i < exp_q.size() && i < mdl.log_q.size(); i++)
      `CHK("access", exp_q[i], mdl.log_q[i])
    flag_skip = 1'b1;
    @(negedge clk);
    flag_skip = 1'b0;
    `CHK("skip", 1'b1, skip)
    `CHK("irq cleared", 1'b0, irq)
    @(negedge clk);
    `CHK("skip pulse", 1'b0, skip)
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test();
  end
  initial begin
    rst_b = 1'b0;
    start_iot = 1'b0;
    flag_skip = 1'b0;
    ptr = 15'h0000;
    slow = 1'b0;
    seed = 32'h3F7BB8B7;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    flag_skip = 1'b1;
    @(negedge clk);
    flag_skip = 1'b0;
    `CHK("idle skip", 1'b0, skip)
    // direct load then exit; a second start mid-run must be ignored
    set_table(15'h0400, 15'h0200, 15'h0400, 15'h0800);
    poke(15'h0200, {fpc_pkg::OP_LOAD, fpc_pkg::FMT_DIRECT, 3'h0, 3'h1});
    poke(15'h0201, 12'h400);
    poke(15'h0202, 12'h000);
    rnd3(15'h1400);
    run_prog(15'h0400, 1'b0, 1'b1);
    // table across a field edge, pre-incremented index, slow memory
    set_table(15'h0FFF, 15'h0200, 15'h1803, 15'h0800);
    poke(15'h0200, {fpc_pkg::OP_LOAD, fpc_pkg::FMT_DIRECT | 3'h1, 3'h5, 3'h1});
    poke(15'h0201, 12'h403);
    poke(15'h1808, 12'h001);
    rnd3(15'h1409);
    run_prog(15'h0FFF, 1'b1, 1'b0);
    // fixed mode: index scaled by 2, two-word operand, sum wraps at 15 bits
    set_table(15'h0600, 15'h0200, 15'h1803, 15'h0800);
    poke(15'h0200, {9'h000, fpc_pkg::OPR_FIX});
    poke(15'h0201, {fpc_pkg::OP_LOAD, fpc_pkg::FMT_DIRECT, 3'h1, 3'h7});
    poke(15'h0202, 12'hFFF);
    poke(15'h0203, 12'h000);
    poke(15'h1804, 12'h001);
    rnd3(15'h0001);
    run_prog(15'h0600, 1'b0, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire

// [testbench/fpc_core_props.sv]
`timescale 1ns/1ns
`default_nettype none
module fpc_core_props (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic start_iot_in,
  input wire logic [14:0] param_table_in,
  input wire logic flag_skip_iot_in,
  input wire logic skip_out,
  input wire logic [11:0] status_out,
  input wire logic irq_out,
  input wire logic run_out,
  input wire logic mem_req_out,
  input wire logic mem_we_out,
  input wire logic [14:0] mem_addr_out,
  input wire logic [11:0] mem_wdata_out,
  input wire logic [11:0] mem_rdata_in,
  input wire logic mem_ack_in
);
  logic [14:0] ptr_r;
  logic [2:0] ld_cnt_r;
  logic dump_r;
  logic take;
  logic go;
  assign take = mem_req_out && mem_ack_in;
  assign go = start_iot_in && !run_out && !irq_out;
  // table pointer of the current run, table words still to load
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ptr_r <= 15'h0000;
      ld_cnt_r <= 3'h0;
    end else if (go) begin
      ptr_r <= param_table_in;
      ld_cnt_r <= 3'h7;
    end else if (take && ld_cnt_r != 3'h0) begin
      ld_cnt_r <= ld_cnt_r - 3'h1;
    end
  end
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dump_r <= 1'b0;
    end else if (take && mem_we_out) begin
      dump_r <= mem_addr_out != ptr_r;
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  a_start_reads_table: assert property (
    go && !mem_req_out |=> mem_req_out && !mem_we_out &&
    mem_addr_out == $past(param_table_in)) else $error("no table read");
  a_request_holds: assert property (
    mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out) &&
    $stable(mem_we_out) && $stable(mem_wdata_out)) else $error("req moved");
  a_skip_word_four: assert property (
    ld_cnt_r != 3'h0 && mem_req_out |-> !mem_we_out &&
    mem_addr_out != ptr_r + 15'h4) else $error("word four read");
  a_dump_descends: assert property (
    take && mem_we_out && mem_addr_out != ptr_r &&
    (dump_r || mem_addr_out == ptr_r + 15'h7) |=> mem_req_out &&
    mem_we_out && mem_addr_out == $past(mem_addr_out) - 15'h1)
    else $error("dump out of order");
  a_flag_after_dump: assert property (
    $rose(irq_out) |-> $past(take && mem_we_out && mem_addr_out == ptr_r, 2))
    else $error("flag before dump end");
  a_exit_stops_run: assert property (
    $rose(irq_out) |-> !run_out && !mem_req_out) else $error("still running");
  a_skip_answers: assert property (
    flag_skip_iot_in && irq_out |=> skip_out && !irq_out && !status_out[0])
    else $error("skip not taken");
  a_skip_refused: assert property (
    flag_skip_iot_in && !irq_out |=> !skip_out) else $error("bad skip");
  c_run_done: cover property ($rose(irq_out));
  c_dump_write: cover property (take && mem_we_out);
  c_skip_taken: cover property (flag_skip_iot_in && irq_out);
endmodule
bind fpc_core fpc_core_props u_props (.core_clk_in(core_clk_in),
  .rst_b_in(rst_b_in), .start_iot_in(start_iot_in),
  .param_table_in(param_table_in), .flag_skip_iot_in(flag_skip_iot_in),
  .skip_out(skip_out), .status_out(status_out), .irq_out(irq_out),
  .run_out(run_out), .mem_req_out(mem_req_out), .mem_we_out(mem_we_out),
  .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
  .mem_rdata_in(mem_rdata_in), .mem_ack_in(mem_ack_in));
`default_nettype wire

// [testbench/fpc_host_mem.sv]
`timescale 1ns/1ns
`default_nettype none
module fpc_host_mem (
  input wire logic core_clk_in,
  input wire logic slow_in,
  input wire logic mem_req_in,
  input wire logic mem_we_in,
  input wire logic [14:0] mem_addr_in,
  input wire logic [11:0] mem_wdata_in,
  output logic [11:0] mem_rdata_out,
  output logic mem_ack_out
);
  logic [11:0] mem [0:32767];
  logic [27:0] log_q [$];
  int waited;
  initial begin
    mem_ack_out = 1'b0;
    mem_rdata_out = 12'h5A5;
    waited = 0;
  end
  // one word per grant; released data bus toggles so stale data never matches
  always @(negedge core_clk_in) begin
    if (mem_req_in && !mem_ack_out && waited >= (slow_in ? 3 : 0)) begin
      mem_ack_out <= 1'b1;
      mem_rdata_out <= mem[mem_addr_in];
      waited <= 0;
    end else begin
      mem_ack_out <= 1'b0;
      mem_rdata_out <= ~mem_rdata_out;
      waited <= mem_req_in ? waited + 1 : 0;
    end
  end
  always @(posedge core_clk_in) begin
    if (mem_req_in && mem_ack_out) begin
      log_q.push_back({mem_we_in, mem_addr_in,
                       mem_we_in ? mem_wdata_in : 12'h000});
      if (mem_we_in) begin
        mem[mem_addr_in] <= mem_wdata_in;
      end
    end
  end
endmodule
`default_nettype wire

// [verilog/fpc_core.sv]
`timescale 1ns/1ns
`default_nettype none
// Function
// RULE_01: host builds table, writes command, starts with pointer, then waits.
// RULE_02: start reads table words 0,1,2,3,5,6,7; never word 4.
// RULE_03: after the low word, first fetch comes from table pc word.
// RULE_04: sequential addresses carry across page and field boundaries.
// RULE_05: second digit 4 is two-word direct; first digit 0 is load.
// RULE_06: direct address from bits 9-23; no indexing when bits 6-8 zero.
// RULE_07: float load fetches exponent, high word, low word in order.
// RULE_08: exit dumps state over table from offset 7 down to 0.
// RULE_09: dump holds field, pc, index base, base, operand, exp, hi, lo.
// RULE_10: completion flag set only after whole dump finished.
// RULE_11: index value multiplied by 3 in float mode, 2 in fixed.
// RULE_12: add in 24 bits, keep low 15 bits.
// RULE_13: pre-increment writes index back to memory before use.
// RULE_14: index loop jump increments first, branches when nonzero.
// RULE_15: fixability jump when exponent exceeds 23 decimal.
// RULE_16: sign and zero jumps test mantissa only.
// RULE_17: reentrant call stores return into bits 21-35 at base entry; code writes it to bits 9-23 (base words 0 and 1).
// RULE_18: accumulator jump loads pc from fraction bits 9-23.
// RULE_19: single-word data references are relative to base register.
// RULE_20: linked call deposits jump to return in first two words.
// RULE_21: add-to-index adds signed constant to index in memory.
// RULE_22: exit dumps registers, clears run, interrupts host.
// RULE_23: index register n lives at index base plus n.
// RULE_24: flag skip returns status and clears flags and request.
// RULE_25: mode bit from mode-start ops sets multiplier and word count.
module fpc_core (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic start_iot_in,
  input wire logic [14:0] param_table_in,
  input wire logic flag_skip_iot_in,
  output logic skip_out,
  output logic [11:0] status_out,
  output logic irq_out,
  output logic run_out,
  output logic mem_req_out,
  output logic mem_we_out,
  output logic [14:0] mem_addr_out,
  output logic [11:0] mem_wdata_out,
  input wire logic [11:0] mem_rdata_in,
  input wire logic mem_ack_in
);
  fpc_mem_if mem();
  fpc_pkg::fpc_state_e st_r;
  logic [14:0] pc_r, xb_r, base_r, opa_r, tbl_r, ea_r;
  logic [11:0] exp_r, hi_r, lo_r, ins_r, ins2_r, xval_r;
  logic [2:0] cnt_r;
  logic float_r, done_r, wr_r;
  logic [14:0] addr_r;
  logic [11:0] wd_r;
  logic [14:0] idx_ea;
  logic [2:0] wcnt;

  function automatic logic cond_met(input logic [2:0] c,
                                    input logic [11:0] h, l, e);
    logic z, n;
    z = (h == 12'h000) && (l == 12'h000); // see RULE_16
    n = h[11];
    case (c)
      fpc_pkg::CJ_ZERO: cond_met = z;
      fpc_pkg::CJ_NNEG: cond_met = !n;
      fpc_pkg::CJ_NPOS: cond_met = n || z;
      fpc_pkg::CJ_ALW: cond_met = 1'b1;
      fpc_pkg::CJ_NZ: cond_met = !z;
      fpc_pkg::CJ_NEG: cond_met = n;
      fpc_pkg::CJ_POS: cond_met = !n && !z;
      default: cond_met = $signed(e) > $signed(fpc_pkg::FIX_LIMIT); // see RULE_15
    endcase
  endfunction

  function automatic logic [11:0] dump_word(input logic [2:0] o,
    input logic [14:0] pc, xb, bs, oa, input logic [11:0] e, h, l);
    case (o)
      fpc_pkg::TB_FIELD: dump_word = {pc[14:12], xb[14:12], bs[14:12],
                                      oa[14:12]};
      fpc_pkg::TB_PC: dump_word = pc[11:0];
      fpc_pkg::TB_XB: dump_word = xb[11:0];
      fpc_pkg::TB_BASE: dump_word = bs[11:0];
      fpc_pkg::TB_OPA: dump_word = oa[11:0];
      fpc_pkg::TB_EXP: dump_word = e;
      fpc_pkg::TB_HI: dump_word = h;
      default: dump_word = l;
    endcase
  endfunction

  fpc_idx_addr u_idx (
    .base_in(ins_r[8] ? {ins_r[2:0], ins2_r} : opa_r),
    .index_in(xval_r),
    .use_in(ins_r[5:3] != 3'h0), // see RULE_06
    .float_in(float_r),
    .addr_out(idx_ea)
  );

  fpc_mem_port u_port (
    .mem(mem.port),
    .req_out(mem_req_out),
    .we_out(mem_we_out),
    .addr_out(mem_addr_out),
    .wdata_out(mem_wdata_out),
    .rdata_in(mem_rdata_in),
    .ack_in(mem_ack_in)
  );

  assign mem.req = !(st_r inside {fpc_pkg::FPC_IDLE, fpc_pkg::FPC_DONE,
                                  fpc_pkg::FPC_INDR});
  assign mem.we = wr_r;
  assign mem.addr = addr_r;
  assign mem.wdata = wd_r;
  assign wcnt = float_r ? 3'h3 : 3'h2; // see RULE_25
  assign run_out = !(st_r inside {fpc_pkg::FPC_IDLE, fpc_pkg::FPC_DONE});
  assign irq_out = done_r; // see RULE_22
  assign status_out = {11'h000, done_r};

  // host flag: set after dump, cleared by skip iot
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      done_r <= 1'b0;
      skip_out <= 1'b0;
    end else begin
      skip_out <= flag_skip_iot_in && done_r;
      if (st_r == fpc_pkg::FPC_DONE) begin
        done_r <= 1'b1; // see RULE_10
      end else if (flag_skip_iot_in && done_r) begin
        done_r <= 1'b0; // see RULE_24
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= fpc_pkg::FPC_IDLE;
      {pc_r, xb_r, base_r, opa_r, tbl_r, ea_r, addr_r} <= '0;
      {exp_r, hi_r, lo_r, ins_r, ins2_r, xval_r, wd_r} <= '0;
      cnt_r <= 3'h0;
      float_r <= 1'b1;
      wr_r <= 1'b0;
    end else begin
      case (st_r)
        fpc_pkg::FPC_IDLE: begin
          if (start_iot_in) begin // see RULE_01
            tbl_r <= param_table_in;
            addr_r <= param_table_in;
            cnt_r <= fpc_pkg::TB_FIELD;
            wr_r <= 1'b0;
            st_r <= fpc_pkg::FPC_LOAD;
          end
        end
        fpc_pkg::FPC_LOAD: if (mem.ack) begin
          case (cnt_r)
            fpc_pkg::TB_FIELD: begin
              pc_r[14:12] <= mem.rdata[11:9];
              xb_r[14:12] <= mem.rdata[8:6];
              base_r[14:12] <= mem.rdata[5:3];
            end
            fpc_pkg::TB_PC: pc_r[11:0] <= mem.rdata;
            fpc_pkg::TB_XB: xb_r[11:0] <= mem.rdata;
            fpc_pkg::TB_BASE: base_r[11:0] <= mem.rdata;
            fpc_pkg::TB_EXP: exp_r <= mem.rdata;
            fpc_pkg::TB_HI: hi_r <= mem.rdata;
            default: lo_r <= mem.rdata;
          endcase
          if (cnt_r == fpc_pkg::TB_LO) begin
            addr_r <= pc_r; // see RULE_03
            st_r <= fpc_pkg::FPC_FETCH;
          end else begin
            // skip operand word on load
            cnt_r <= (cnt_r == fpc_pkg::TB_BASE) ? fpc_pkg::TB_EXP
                                                 : cnt_r + 3'h1; // see RULE_02
            addr_r <= tbl_r + ((cnt_r == fpc_pkg::TB_BASE) ?
                      15'(fpc_pkg::TB_EXP) : 15'(cnt_r + 3'h1)); // see RULE_04
          end
        end
        fpc_pkg::FPC_FETCH: if (mem.ack) begin
          ins_r <= mem.rdata;
          pc_r <= pc_r + 15'h0001; // see RULE_04
          addr_r <= pc_r + 15'h0001;
          if ({mem.rdata[8:7], 1'b0} == fpc_pkg::FMT_DIRECT || // see RULE_05
              mem.rdata[8:6] == fpc_pkg::FMT_JUMP ||
              (mem.rdata[8:6] == fpc_pkg::FMT_SPEC &&
               (mem.rdata[5:3] != 3'h0 ||
                mem.rdata[11:9] == fpc_pkg::SP_LOOP))) begin
            st_r <= fpc_pkg::FPC_FETCH2;
          end else if (mem.rdata[8:7] == 2'h1) begin
            opa_r <= base_r + 15'(mem.rdata[6:0]) * 15'h0003; // see RULE_19
            ea_r <= base_r + 15'(mem.rdata[6:0]) * 15'h0003;
            addr_r <= base_r + 15'(mem.rdata[6:0]) * 15'h0003;
            cnt_r <= 3'h0;
            wr_r <= mem.rdata[11:9] == fpc_pkg::OP_STORE;
            wd_r <= float_r ? exp_r : hi_r;
            st_r <= fpc_pkg::FPC_DATA;
          end else begin
            case (mem.rdata[2:0])
              fpc_pkg::OPR_EXIT: begin
                cnt_r <= fpc_pkg::TB_LO;
                addr_r <= tbl_r + 15'(fpc_pkg::TB_LO); // see RULE_08
                wd_r <= lo_r;
                wr_r <= 1'b1;
                st_r <= fpc_pkg::FPC_DUMP;
              end
              fpc_pkg::OPR_FLT: begin
                float_r <= 1'b1; // see RULE_25
                addr_r <= pc_r + 15'h0001;
              end
              fpc_pkg::OPR_FIX: float_r <= 1'b0;
              fpc_pkg::OPR_AJMP: begin
                pc_r <= {hi_r[2:0], lo_r}; // see RULE_18
                addr_r <= {hi_r[2:0], lo_r};
              end
              default: ;
            endcase
          end
        end
        fpc_pkg::FPC_FETCH2: if (mem.ack) begin
          ins2_r <= mem.rdata;
          pc_r <= pc_r + 15'h0001;
          opa_r <= {ins_r[2:0], mem.rdata}; // see RULE_06
          addr_r <= xb_r + 15'(ins_r[5:3]); // see RULE_23
          cnt_r <= 3'h0;
          st_r <= fpc_pkg::FPC_XRD;
          if ({ins_r[8:7], 1'b0} == fpc_pkg::FMT_DIRECT && ins_r[5:3] == 3'h0)
            st_r <= fpc_pkg::FPC_INDR; // see RULE_06
          if (ins_r[8:6] == fpc_pkg::FMT_JUMP) begin
            if (ins_r[11:9] == fpc_pkg::PT_CALL && ins_r[5]) begin
              ea_r <= {ins_r[2:0], mem.rdata};
              addr_r <= base_r;
              wd_r <= {9'h000, 3'((pc_r + 15'h0001) >> 12)}; // see RULE_17
              wr_r <= 1'b1;
              st_r <= fpc_pkg::FPC_WR;
            end else if (ins_r[11:9] == fpc_pkg::PT_LINK && ins_r[5]) begin
              ea_r <= {ins_r[2:0], mem.rdata} + 15'h0002;
              addr_r <= {ins_r[2:0], mem.rdata};
              wd_r <= fpc_pkg::JUMP_WORD | {9'h000, (pc_r[14:12] +
                      3'(mem.rdata == 12'hFFF))}; // see RULE_20
              xval_r <= pc_r[11:0] + 12'h001;
              wr_r <= 1'b1;
              st_r <= fpc_pkg::FPC_WR;
            end else if (ins_r[5]) begin
              pc_r <= {ins_r[2:0], mem.rdata};
              addr_r <= {ins_r[2:0], mem.rdata};
              if (ins_r[11:9] == fpc_pkg::PT_SETX) xb_r <= {ins_r[2:0], mem.rdata};
              if (ins_r[11:9] == fpc_pkg::PT_SETB) base_r <= {ins_r[2:0], mem.rdata};
              if (ins_r[11:9] <= fpc_pkg::PT_SETB) pc_r <= pc_r + 15'h0001;
              if (ins_r[11:9] <= fpc_pkg::PT_SETB) addr_r <= pc_r + 15'h0001;
              st_r <= fpc_pkg::FPC_FETCH;
            end else if (cond_met(ins_r[11:9], hi_r, lo_r, exp_r)) begin
              pc_r <= {ins_r[2:0], mem.rdata};
              addr_r <= {ins_r[2:0], mem.rdata};
              st_r <= fpc_pkg::FPC_FETCH;
            end else begin
              addr_r <= pc_r + 15'h0001;
              st_r <= fpc_pkg::FPC_FETCH;
            end
          end
        end
        fpc_pkg::FPC_XRD: if (mem.ack) begin
          xval_r <= mem.rdata;
          if (ins_r[8:6] == fpc_pkg::FMT_SPEC) begin
            wr_r <= 1'b1;
            st_r <= fpc_pkg::FPC_XWR;
            if ({ins_r[5:0]} == fpc_pkg::SP_LDX) wd_r <= ins2_r;
            else if (ins_r[5:0] == fpc_pkg::SP_ADD_TO_INDEX)
              wd_r <= mem.rdata + ins2_r; // see RULE_21
            else wd_r <= mem.rdata + 12'h001; // see RULE_14
            if (ins_r[5:0] == fpc_pkg::SP_LDX) xval_r <= ins2_r;
            if (ins_r[5:0] == fpc_pkg::SP_ADD_TO_INDEX) xval_r <= mem.rdata + ins2_r;
            if (ins_r[11:9] == fpc_pkg::SP_LOOP) xval_r <= mem.rdata + 12'h001;
          end else if (ins_r[6] && ins_r[5:3] != 3'h0) begin
            xval_r <= mem.rdata + 12'h001;
            wd_r <= mem.rdata + 12'h001; // see RULE_13
            wr_r <= 1'b1;
            st_r <= fpc_pkg::FPC_XWR;
          end else begin
            st_r <= fpc_pkg::FPC_INDR;
          end
        end
        fpc_pkg::FPC_XWR: if (mem.ack) begin
          wr_r <= 1'b0;
          if (ins_r[8:6] == fpc_pkg::FMT_SPEC) begin
            if (ins_r[11:9] == fpc_pkg::SP_LOOP && xval_r != 12'h000) begin
              pc_r <= opa_r; // see RULE_14
              addr_r <= opa_r;
            end else begin
              addr_r <= pc_r;
            end
            st_r <= fpc_pkg::FPC_FETCH;
          end else begin
            st_r <= fpc_pkg::FPC_INDR;
          end
        end
        fpc_pkg::FPC_INDR: begin
          opa_r <= idx_ea;
          ea_r <= idx_ea;
          addr_r <= idx_ea;
          wr_r <= ins_r[11:9] == fpc_pkg::OP_STORE;
          wd_r <= float_r ? exp_r : hi_r;
          cnt_r <= 3'h0;
          st_r <= fpc_pkg::FPC_DATA;
        end
        fpc_pkg::FPC_DATA: if (mem.ack) begin
          if (!wr_r && ins_r[11:9] == fpc_pkg::OP_LOAD) begin
            case (cnt_r + (float_r ? 3'h0 : 3'h1)) // see RULE_07
              3'h0: exp_r <= mem.rdata;
              3'h1: hi_r <= mem.rdata;
              default: lo_r <= mem.rdata;
            endcase
          end
          wd_r <= (cnt_r + (float_r ? 3'h0 : 3'h1) == 3'h0) ? hi_r : lo_r;
          addr_r <= addr_r + 15'h0001;
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r + 3'h1 == wcnt) begin
            wr_r <= 1'b0;
            addr_r <= pc_r;
            st_r <= fpc_pkg::FPC_FETCH;
          end
        end
        fpc_pkg::FPC_WR: if (mem.ack) begin
          addr_r <= addr_r + 15'h0001;
          wd_r <= (ins_r[11:9] == fpc_pkg::PT_CALL) ? pc_r[11:0] : xval_r;
          if (addr_r != base_r + 15'h0001 &&
              addr_r != ea_r - 15'h0001) begin
            if (ins_r[11:9] == fpc_pkg::PT_CALL) addr_r <= base_r + 15'h0001;
          end else begin
            wr_r <= 1'b0;
            pc_r <= ea_r;
            addr_r <= ea_r;
            st_r <= fpc_pkg::FPC_FETCH;
          end
        end
        fpc_pkg::FPC_DUMP: if (mem.ack) begin
          if (cnt_r == fpc_pkg::TB_FIELD) begin
            wr_r <= 1'b0;
            st_r <= fpc_pkg::FPC_DONE; // see RULE_22
          end else begin
            cnt_r <= cnt_r - 3'h1;
            addr_r <= tbl_r + 15'(cnt_r - 3'h1); // see RULE_09
            wd_r <= dump_word(cnt_r - 3'h1, pc_r, xb_r, base_r, opa_r,
                              exp_r, hi_r, lo_r);
          end
        end
        fpc_pkg::FPC_DONE: st_r <= fpc_pkg::FPC_IDLE;
        default: st_r <= fpc_pkg::FPC_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// [verilog/fpc_idx_addr.sv]
`timescale 1ns/1ns
`default_nettype none
// scaled index added at 24 bits, then cut to 15 bits
module fpc_idx_addr (
  input wire logic [14:0] base_in,
  input wire logic [11:0] index_in,
  input wire logic use_in,
  input wire logic float_in,
  output logic [14:0] addr_out
);
  logic [23:0] scaled;
  logic [23:0] sum;
  always_comb begin
    scaled = {{12{index_in[11]}}, index_in} *
      (float_in ? 24'(fpc_pkg::MUL_FLT) : 24'(fpc_pkg::MUL_FIX)); // see RULE_11
    sum = {9'h000, base_in} + (use_in ? scaled : 24'h000000);
    addr_out = sum[14:0]; // see RULE_12
  end
endmodule
`default_nettype wire

// [verilog/fpc_mem_port.sv]
`timescale 1ns/1ns
`default_nettype none
// forwards the shared-memory cycle to the top-level pins
module fpc_mem_port (
  fpc_mem_if.port mem,
  output logic req_out,
  output logic we_out,
  output logic [14:0] addr_out,
  output logic [11:0] wdata_out,
  input wire logic [11:0] rdata_in,
  input wire logic ack_in
);
  assign req_out = mem.req;
  assign we_out = mem.we;
  assign addr_out = mem.addr;
  assign wdata_out = mem.wdata;
  assign mem.rdata = rdata_in;
  assign mem.ack = ack_in;
endmodule
`default_nettype wire
